// >>> design/tbpd_defines.svh
// bit positions, codes and constants for the texture block palette decoder
`ifndef TBPD_DEFINES_SVH
`define TBPD_DEFINES_SVH
`define TBPD_MODE_HI 127
`define TBPD_MODE_LO 125
`define TBPD_ALPHA_CODE 3'h3
`define TBPD_MIXED_BIT 127
`define TBPD_FLAG_BIT 124
`define TBPD_G3_LSB 126
`define TBPD_G1_LSB 125
`define TBPD_C0_BASE 64
`define TBPD_C1_BASE 79
`define TBPD_C2_BASE 94
`define TBPD_C3_BASE 109
`define TBPD_A0_LO 109
`define TBPD_A1_LO 114
`define TBPD_A2_LO 119
`define TBPD_R_OFS 10
`define TBPD_G_OFS 5
`define TBPD_TEXELS 32
`define TBPD_HALF 16
`define TBPD_OPAQUE 8'hff
`define TBPD_IDX_C0 2'h0
`define TBPD_IDX_MID 2'h1
`define TBPD_IDX_MID2 2'h2
`define TBPD_IDX_LAST 2'h3
`endif

// >>> design/tbpd_pkg.sv
// types shared by the texture block palette decoder
package tbpd_pkg;
	typedef logic [31:0] tbpd_argb_t;
	typedef logic [127:0] tbpd_block_t;
	typedef tbpd_argb_t [31:0] tbpd_texels_t;
	typedef tbpd_argb_t [3:0] tbpd_table_t;
	typedef enum logic [1:0] {
		TBPD_NONE,
		TBPD_MIXED_ALPHA,
		TBPD_ALPHA_DIRECT,
		TBPD_ALPHA_INTERP_SELECT
	} tbpd_mode_t;
endpackage

// >>> design/tbpd_decoder.sv
// decoder for mixed (alpha flag set) and alpha colour mode texture blocks
//
// Contract
// - mixed colour mode uses bit 124 as the mixed alpha flag
// - flag set: colours 0,2 are 555; colours 1,3 are 565, green lsb 125/126
// - mixed: texels 0-15 use colours 0/1 table, texels 16-31 colours 2/3
// - lower mixed table: c0, average of c0 and c1, c1, alpha ff
// - upper mixed table: c2, average of c2 and c3, c3, alpha ff
// - mixed index 3 gives black with alpha zero
// - each texel's 2-bit select picks a 32-bit argb table entry
// - top bits 127:125 equal to 011 mean alpha colour mode
// - alpha mode bit 124 picks direct table or two interpolated tables
// - alpha fields: colour 2 at 123:119, colour 1 114, colour 0 109
// - rgb fields: colour 2 from 108, colour 1 from 93, colour 0 from 78
// - texel n select sits at bits 2n+1:2n of the low 64 bits
// - 5-bit channels widen to 8 by repeating their top three bits
// - interp_select 0: one table c0,c1,c2 with own alpha, then clear
// - interp_select 1: texels 0-15 use c0/c1, texels 16-31 use c2/c1
// - lower table: c0, (2c0+c1+1)/3, (c0+2c1+1)/3, c1 per channel
// - upper table: c2, (2c2+c1+1)/3, (c2+2c1+1)/3, c1 per channel
`timescale 1ns/100ps
`default_nettype none
`include "tbpd_defines.svh"

module tbpd_decoder (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	input wire tbpd_pkg::tbpd_block_t in_block,
	output logic out_valid,
	output tbpd_pkg::tbpd_mode_t out_mode,
	output tbpd_pkg::tbpd_texels_t out_texels
);
	import tbpd_pkg::*;

	logic out_valid_q;
	tbpd_mode_t mode_q;
	tbpd_mode_t mode_d;
	tbpd_texels_t texels_q;
	tbpd_texels_t texels_d;
	tbpd_table_t lo_tab;
	tbpd_table_t hi_tab;
	tbpd_argb_t c0;
	tbpd_argb_t c1;
	tbpd_argb_t c2;
	tbpd_argb_t c3;

	// widen a 5-bit channel to 8 bits
	function automatic logic [7:0] exp5(input logic [4:0] f);
		return {f, f[4:2]};
	endfunction

	// 555 colour at a field base, with a given alpha byte
	function automatic tbpd_argb_t rgb555(input tbpd_block_t b,
		input int base, input logic [7:0] a);
		logic [4:0] r;
		logic [4:0] g;
		logic [4:0] bl;
		r = b[base + `TBPD_R_OFS +: 5];
		g = b[base + `TBPD_G_OFS +: 5];
		bl = b[base +: 5];
		return {a, exp5(r), exp5(g), exp5(bl)};
	endfunction

	// 565 colour: green gets the extra low bit from the block
	function automatic tbpd_argb_t rgb565(input tbpd_block_t b,
		input int base, input logic lsb);
		logic [4:0] g;
		tbpd_argb_t c;
		g = b[base + `TBPD_G_OFS +: 5];
		c = rgb555(b, base, `TBPD_OPAQUE);
		c[15:8] = {g, lsb, g[4:3]};
		return c;
	endfunction

	// per-channel average, truncating
	function automatic tbpd_argb_t avg2(input tbpd_argb_t x,
		input tbpd_argb_t y);
		logic [8:0] s;
		tbpd_argb_t r;
		r = '0;
		for (int i = 0; i < 4; i++) begin
			s = {1'b0, x[i*8 +: 8]} + {1'b0, y[i*8 +: 8]};
			r[i*8 +: 8] = s[8:1];
		end
		return r;
	endfunction

	// per-channel (2x+y+1)/3 with a 10-bit sum
	function automatic tbpd_argb_t lerp3(input tbpd_argb_t x,
		input tbpd_argb_t y);
		logic [9:0] s;
		logic [9:0] q;
		tbpd_argb_t r;
		r = '0;
		for (int i = 0; i < 4; i++) begin
			s = {1'b0, x[i*8 +: 8], 1'b0} + {2'h0, y[i*8 +: 8]} + 10'h001;
			q = s / 10'h003;
			r[i*8 +: 8] = q[7:0];
		end
		return r;
	endfunction

	// mode decode from the top bits and the flag bit
	always_comb begin
		mode_d = TBPD_NONE;
		if (in_block[`TBPD_MODE_HI:`TBPD_MODE_LO] == `TBPD_ALPHA_CODE) begin
			mode_d = in_block[`TBPD_FLAG_BIT] ? TBPD_ALPHA_INTERP_SELECT :
				TBPD_ALPHA_DIRECT;
		end else if (in_block[`TBPD_MIXED_BIT] && in_block[`TBPD_FLAG_BIT]) begin
			mode_d = TBPD_MIXED_ALPHA;
		end
	end

	// base colours for the decoded mode
	always_comb begin
		c3 = '0;
		if (mode_d == TBPD_MIXED_ALPHA) begin
			c0 = rgb555(in_block, `TBPD_C0_BASE, `TBPD_OPAQUE);
			c1 = rgb565(in_block, `TBPD_C1_BASE, in_block[`TBPD_G1_LSB]);
			c2 = rgb555(in_block, `TBPD_C2_BASE, `TBPD_OPAQUE);
			c3 = rgb565(in_block, `TBPD_C3_BASE, in_block[`TBPD_G3_LSB]);
		end else begin
			c0 = rgb555(in_block, `TBPD_C0_BASE,
				exp5(in_block[`TBPD_A0_LO +: 5]));
			c1 = rgb555(in_block, `TBPD_C1_BASE,
				exp5(in_block[`TBPD_A1_LO +: 5]));
			c2 = rgb555(in_block, `TBPD_C2_BASE,
				exp5(in_block[`TBPD_A2_LO +: 5]));
		end
	end

	// the two four-entry tables
	always_comb begin
		lo_tab = '0;
		hi_tab = '0;
		case (mode_d)
			TBPD_MIXED_ALPHA: begin
				lo_tab[`TBPD_IDX_C0] = c0;
				lo_tab[`TBPD_IDX_MID] = avg2(c0, c1);
				lo_tab[`TBPD_IDX_MID2] = c1;
				hi_tab[`TBPD_IDX_C0] = c2;
				hi_tab[`TBPD_IDX_MID] = avg2(c2, c3);
				hi_tab[`TBPD_IDX_MID2] = c3;
			end
			TBPD_ALPHA_DIRECT: begin
				// one direct table, last entry clear
				lo_tab[`TBPD_IDX_C0] = c0;
				lo_tab[`TBPD_IDX_MID] = c1;
				lo_tab[`TBPD_IDX_MID2] = c2;
				hi_tab = lo_tab;
			end
			TBPD_ALPHA_INTERP_SELECT: begin
				lo_tab[`TBPD_IDX_C0] = c0;
				lo_tab[`TBPD_IDX_MID] = lerp3(c0, c1);
				lo_tab[`TBPD_IDX_MID2] = lerp3(c1, c0);
				lo_tab[`TBPD_IDX_LAST] = c1;
				hi_tab[`TBPD_IDX_C0] = c2;
				hi_tab[`TBPD_IDX_MID] = lerp3(c2, c1);
				hi_tab[`TBPD_IDX_MID2] = lerp3(c1, c2);
				hi_tab[`TBPD_IDX_LAST] = c1;
			end
			default: begin
				lo_tab = '0;
				hi_tab = '0;
			end
		endcase
	end

	// per-texel lookup
	always_comb begin
		texels_d = '0;
		for (int n = 0; n < `TBPD_TEXELS; n++) begin
			if (n < `TBPD_HALF) begin
				texels_d[n] = lo_tab[in_block[2*n +: 2]];
			end else begin
				texels_d[n] = hi_tab[in_block[2*n +: 2]];
			end
		end
	end

	// output valid, one cycle after the block
	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid_q <= 1'b0;
		end else begin
			out_valid_q <= in_valid;
		end
	end

	// result registers, loaded with each valid block
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_q <= TBPD_NONE;
			texels_q <= '0;
		end else if (in_valid) begin
			mode_q <= mode_d;
			texels_q <= texels_d;
		end
	end

	assign out_valid = out_valid_q;
	assign out_mode = mode_q;
	assign out_texels = texels_q;

	// checks on decoded output against the block one cycle earlier
	a_result_latency: assert property (@(posedge clk) disable iff (rst)
		in_valid |=> out_valid_q && mode_q == $past(mode_d))
		else $error("result not one cycle after block");

	a_alpha_mode_code: assert property (@(posedge clk) disable iff (rst)
		in_valid && in_block[127:125] == 3'h3 |=>
		mode_q == TBPD_ALPHA_DIRECT || mode_q == TBPD_ALPHA_INTERP_SELECT)
		else $error("alpha mode code not recognised");

	a_interp_flag: assert property (@(posedge clk) disable iff (rst)
		in_valid && in_block[127:125] == 3'h3 ##1 out_valid_q |->
		(mode_q == TBPD_ALPHA_INTERP_SELECT) == $past(in_block[124]))
		else $error("interp_select not followed");

	a_mixed_black: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_MIXED_ALPHA &&
		$past(in_block[63:62]) == 2'h3 |-> texels_q[31] == 32'h0)
		else $error("mixed index 3 not clear black");

	a_mixed_lower: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_MIXED_ALPHA &&
		$past(in_block[1:0]) == 2'h0 |->
		texels_q[0] == {8'hff, exp5($past(in_block[78:74])),
		exp5($past(in_block[73:69])), exp5($past(in_block[68:64]))})
		else $error("mixed lower index 0 wrong");

	a_mixed_upper: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_MIXED_ALPHA &&
		$past(in_block[63:62]) == 2'h2 |->
		texels_q[31][31:16] == {8'hff, exp5($past(in_block[123:119]))} &&
		texels_q[31][2:0] == $past(in_block[113:111]))
		else $error("mixed upper colour 3 wrong");

	a_mixed_green: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_MIXED_ALPHA &&
		$past(in_block[1:0]) == 2'h2 |->
		texels_q[0][10] == $past(in_block[125]))
		else $error("colour 1 green lsb wrong");

	a_direct_alpha: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_ALPHA_DIRECT &&
		$past(in_block[63:62]) == 2'h2 |->
		texels_q[31][31:24] == exp5($past(in_block[123:119])))
		else $error("direct table colour 2 alpha wrong");

	a_interp_select_ends: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_ALPHA_INTERP_SELECT &&
		$past(in_block[63:62]) == 2'h3 |->
		texels_q[31][31:24] == exp5($past(in_block[118:114])))
		else $error("upper interp_select index 3 not colour 1");

	a_interp_select_equal: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_ALPHA_INTERP_SELECT &&
		$past(in_block[1:0]) == 2'h1 &&
		$past(in_block[113:109]) == $past(in_block[118:114]) |->
		texels_q[0][31:24] == exp5($past(in_block[113:109])))
		else $error("interp_select of equal alphas not exact");

	a_mixed_mid_avg: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_MIXED_ALPHA &&
		$past(in_block[63:62]) == `TBPD_IDX_MID |->
		texels_q[31][31:24] == `TBPD_OPAQUE &&
		texels_q[31][23:16] == 8'((9'(exp5($past(in_block[123:119]))) +
		9'(exp5($past(in_block[108:104])))) >> 1))
		else $error("upper mixed average wrong");

	a_direct_clear: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_ALPHA_DIRECT &&
		$past(in_block[1:0]) == `TBPD_IDX_LAST |-> texels_q[0] == '0)
		else $error("direct index 3 not transparent black");

	a_flag_clear_none: assert property (@(posedge clk) disable iff (rst)
		out_valid_q && $past(in_block[`TBPD_MIXED_BIT]) &&
		!$past(in_block[`TBPD_FLAG_BIT]) |->
		mode_q == TBPD_NONE && texels_q == '0)
		else $error("mixed block with flag clear decoded");

	// main scenario covers
	c_mixed_seen: cover property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_MIXED_ALPHA);
	c_direct_seen: cover property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_ALPHA_DIRECT);
	c_interp_select_b2b: cover property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_ALPHA_INTERP_SELECT ##1
		out_valid_q && mode_q == TBPD_ALPHA_INTERP_SELECT);
	c_mixed_black: cover property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_MIXED_ALPHA && texels_q[31] == '0);
	c_none_seen: cover property (@(posedge clk) disable iff (rst)
		out_valid_q && mode_q == TBPD_NONE);
endmodule

`default_nettype wire

// >>> verif/tbpd_fetch_model.sv
// texture fetch unit model that presents encoded blocks to the decoder
`timescale 1ns/100ps
`default_nettype none
module tbpd_fetch_model (
	input wire logic clk,
	input wire logic send,
	input wire tbpd_pkg::tbpd_block_t blk,
	output logic in_valid,
	output tbpd_pkg::tbpd_block_t in_block
);
	import tbpd_pkg::*;
	// idle at time zero
	initial begin
		in_valid = 1'b0;
		in_block = '0;
	end
	// present on the falling edge; an idle bus shows the inverse value
	always @(negedge clk) begin
		in_valid <= send;
		in_block <= send ? blk : ~in_block;
	end
endmodule
`default_nettype wire

// >>> verif/tb_tbpd_decoder.sv
// self-checking bench for the texture block palette decoder
`timescale 1ns/100ps
`default_nettype none
module tb_tbpd_decoder;
	import tbpd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic send = 1'b0;
	tbpd_block_t blk = '0;
	logic in_valid;
	tbpd_block_t in_block;
	logic out_valid;
	tbpd_mode_t out_mode;
	tbpd_texels_t out_texels;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	tbpd_block_t q[$];
	// 20 MHz clock
	always #25 clk = ~clk;
	// block source and decoder
	tbpd_fetch_model tbpd_fetch_model_inst (.clk(clk), .send(send),
		.blk(blk), .in_valid(in_valid), .in_block(in_block));
	tbpd_decoder tbpd_decoder_inst (.clk(clk), .rst(rst),
		.in_valid(in_valid), .in_block(in_block), .out_valid(out_valid),
		.out_mode(out_mode), .out_texels(out_texels));
	// reference decode helpers
	function automatic logic [7:0] e5(logic [4:0] v);
		return {v, v[4:2]};
	endfunction
	function automatic tbpd_argb_t col(tbpd_block_t b, int base, int ab,
		bit six, bit lsb);
		logic [4:0] g;
		logic [7:0] a;
		g = b[base + 5 +: 5];
		a = 8'hff;
		if (ab > 0) a = e5(b[ab +: 5]);
		return {a, e5(b[base + 10 +: 5]), six ? {g, lsb, g[4:3]} : e5(g),
			e5(b[base +: 5])};
	endfunction
	function automatic tbpd_argb_t mix(tbpd_argb_t x, tbpd_argb_t y, int w);
		tbpd_argb_t r;
		int p;
		int s;
		for (int i = 0; i < 4; i++) begin
			p = x[8 * i +: 8];
			s = y[8 * i +: 8];
			r[8 * i +: 8] = 8'((w == 2) ? (p + s) / 2 : (2 * p + s + 1) / 3);
		end
		return r;
	endfunction
	function automatic tbpd_mode_t exp_mode(tbpd_block_t b);
		if (b[127:125] == 3'h3)
			return b[124] ? TBPD_ALPHA_INTERP_SELECT : TBPD_ALPHA_DIRECT;
		if (b[127] && b[124]) return TBPD_MIXED_ALPHA;
		return TBPD_NONE;
	endfunction
	function automatic tbpd_texels_t exp_tex(tbpd_block_t b);
		tbpd_argb_t c0, c1, c2, c3;
		tbpd_table_t lo, hi;
		tbpd_texels_t t;
		if (b[127:125] == 3'h3) begin
			c0 = col(b, 64, 109, 0, 0);
			c1 = col(b, 79, 114, 0, 0);
			c2 = col(b, 94, 119, 0, 0);
			lo = {32'h0, c2, c1, c0};
			hi = lo;
			if (b[124]) begin
				lo = {c1, mix(c1, c0, 3), mix(c0, c1, 3), c0};
				hi = {c1, mix(c1, c2, 3), mix(c2, c1, 3), c2};
			end
		end else if (b[127] && b[124]) begin
			c0 = col(b, 64, 0, 0, 0);
			c1 = col(b, 79, 0, 1, b[125]);
			c2 = col(b, 94, 0, 0, 0);
			c3 = col(b, 109, 0, 1, b[126]);
			lo = {32'h0, c1, mix(c0, c1, 2), c0};
			hi = {32'h0, c3, mix(c2, c3, 2), c2};
		end else
			return '0;
		for (int n = 0; n < 32; n++)
			t[n] = (n < 16) ? lo[b[2 * n +: 2]] : hi[b[2 * n +: 2]];
		return t;
	endfunction
	// compare and count
	task automatic check(string what, logic [1023:0] seen,
		logic [1023:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// send the queued blocks back to back, then check the idle cycle
	task automatic stream();
		@(posedge clk);
		send = 1'b1;
		blk = q[0];
		foreach (q[i]) begin
			@(posedge clk);
			if (i + 1 < q.size()) blk = q[i + 1];
			else send = 1'b0;
			@(negedge clk);
			check("valid", out_valid, 1'b1); // one result per block
			check("mode", out_mode, exp_mode(q[i])); // mode pick
			check("texels", out_texels, exp_tex(q[i])); // lookup
		end
		@(negedge clk);
		check("idle valid", out_valid, 1'b0); // single pulse
		check("held", out_texels, exp_tex(q[q.size() - 1])); // held
		q.delete();
	endtask
	task automatic reset_state();
		check("rst valid", out_valid, 1'b0); // idle after reset
		check("rst mode", out_mode, TBPD_NONE); // no mode yet
		check("rst texels", out_texels, '0); // cleared texels
	endtask
	task automatic test_mixed();
		q = '{128'hb5a39c6ef1027d48e4e4e4e41b1b1b1b,
			128'hd3c5a7e90b1d2f461b1be4e4e4e41b1b};
		stream();
	endtask
	task automatic test_direct();
		q = '{128'h6e2d4c8ba9f31057e4e4e4e4e4e4e4e4,
			128'h69f00f0ffff000001b1be4e41b1be4e4};
		stream(); // direct table
	endtask
	task automatic test_interp_select();
		q = '{128'h7fc01ffe003ff801e4e41b1be4e41b1b,
			128'h7a5a5a5aa5a55a5ae4e4e4e41b1b1b1b};
		stream();
	endtask
	task automatic test_none();
		q = '{128'ha5f3c2d1e0b49786e4e4e4e4e4e4e4e4,
			128'h3fffffffffffffffe4e4e4e4e4e4e4e4,
			128'h5fffffffffffffffe4e4e4e4e4e4e4e4};
		stream(); // unsupported blocks
	endtask
	task automatic test_reset();
		q = '{128'h7c1f07c1f07c1f07e4e4e4e4e4e4e4e4};
		stream(); // select positions
		rst = 1'b1;
		@(negedge clk);
		reset_state();
		rst = 1'b0;
	endtask
	// selects that reach the corner entries of every table kind
	task automatic test_corners();
		q = '{128'hb96c3a5e7d21f0c89c4e27e4e4e4e4e4,
			128'hf1e2d3c4b5a697884e4e4e4e4e4e4e4e,
			128'h6a5c3e71d2b8f0468e4e4e4e4e4e4e4f,
			128'h7056a3c96e1b47d21be4e4e41be4e4e5};
		stream(); // corners
	endtask
	// closing report
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			results();
		end
	end
	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		reset_state();
		rst = 1'b0;
		test_mixed();
		test_direct();
		test_interp_select();
		test_none();
		test_reset();
		test_mixed();
		test_corners();
		results();
	end
endmodule
`default_nettype wire
